// ===== pkg/nvram_pkg.sv
// Purpose: shared constants for the two-wire byte memory slave
// Assumes: 200 MHz ref_clk samples the bus pins
// Notes:   all widths and codes are named once here
package nvram_pkg;

  // ==========================================================
  // Array geometry
  // ==========================================================
  localparam int unsigned DEPTH      = 32768;   // Byte locations
  localparam int unsigned ADDR_W     = 15;      // Location width
  localparam int unsigned DATA_W     = 8;       // Byte width

  // ==========================================================
  // Slave address fields
  // ==========================================================
  localparam logic [3:0] DEV_TYPE    = 4'ha;    // Device type 1010
  localparam int unsigned TYPE_LSB   = 4;       // Type field low bit
  localparam int unsigned SEL_LSB    = 1;       // Strap field low bit
  localparam int unsigned DIR_BIT    = 0;       // Direction bit
  localparam logic [4:0] HS_CODE     = 5'h01;   // Master code 00001
  localparam int unsigned HS_LSB     = 3;       // Master code low bit
  localparam logic [ADDR_W-1:0] LOC_RESET = 15'h0000; // Counter reset
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;  // Shifter reset

  // ==========================================================
  // Bus timing
  // ==========================================================
  localparam int unsigned CLK_MHZ    = 200;     // ref_clk rate
  localparam int unsigned HS_KHZ     = 3400;    // Fastest bus rate

  // ==========================================================
  // Protocol states
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,   // Waiting for START
    ST_SLAVE = 3'b001,   // Receiving slave address
    ST_ADRH  = 3'b010,   // High location byte
    ST_ADRL  = 3'b011,   // Low location byte
    ST_WDATA = 3'b100,   // Write data bytes
    ST_RDATA = 3'b101,   // Read data bytes
    ST_HSWT  = 3'b110    // Master code seen, wait repeated START
  } state_t;

endpackage

// ===== core/nvram_array.sv
// Purpose: byte storage array with one write and one read port
// Assumes: synchronous write, combinational read
// Notes:   contents are not reset, like real nonvolatile cells
module nvram_array #(
  parameter int unsigned AW = nvram_pkg::ADDR_W,
  parameter int unsigned DW = nvram_pkg::DATA_W
) (
  input  wire logic          ref_clk,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] rd_data
);

  // ==========================================================
  // Storage
  // ==========================================================
  // byte wide array
  logic [DW-1:0] mem_q [0:(1<<AW)-1];   // Cells

  // Write port
  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem_q[addr] <= wr_data;
    end
  end

  // Read port
  assign rd_data = mem_q[addr];

endmodule // nvram_array

// ===== core/nvram_i2c_slave.sv
// Purpose: two-wire slave front end of a byte memory
// Assumes: SCL and SDA are sampled by ref_clk through 2 flops
// Notes:   SDA driven open drain, oe low means pull low
module nvram_i2c_slave (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic [2:0] chip_select_straps,
  input  wire logic       write_protect,
  output logic            hs_mode,
  output logic            busy
);

  localparam int unsigned AW = nvram_pkg::ADDR_W;
  localparam int unsigned DW = nvram_pkg::DATA_W;

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Sample rate must resolve the fastest bus clock
  if (nvram_pkg::CLK_MHZ * 1000 < 8 * nvram_pkg::HS_KHZ) begin : g_chk
    $error("ref_clk too slow for high speed bus");
  end

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_s1_q;   // Reset sync first stage
  logic rst_s2_q;   // Reset sync second stage

  // Two flop reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire logic rst_sync_n = rst_s2_q;   // Internal reset

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // straps sampled as plain levels, pulled down off chip
  logic [5:0] pin1_q;   // First stages
  logic [5:0] pin2_q;   // Second stages
  logic       scl_d1_q; // Previous SCL
  logic       sda_d1_q; // Previous SDA

  // Synchronise SCL, SDA, write protect, straps
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin1_q   <= 6'h03;
      pin2_q   <= 6'h03;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else if (clk_en) begin
      pin1_q   <= {chip_select_straps, write_protect, sda_i, scl_i};
      pin2_q   <= pin1_q;
      scl_d1_q <= pin2_q[0];
      sda_d1_q <= pin2_q[1];
    end
  end

  wire logic       scl_s  = pin2_q[0];     // Synced SCL
  wire logic       sda_s  = pin2_q[1];     // Synced SDA
  wire logic       wp_s   = pin2_q[2];     // Synced write protect
  wire logic [2:0] sel_s  = pin2_q[5:3];   // Synced straps

  wire logic scl_rise = scl_s & ~scl_d1_q;   // Sample point
  wire logic scl_fall = ~scl_s & scl_d1_q;   // Shift point
  // START is SDA falling with SCL high
  wire logic start_ev = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  // STOP is SDA rising with SCL high
  wire logic stop_ev  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  // ==========================================================
  // Address decode
  // ==========================================================
  // type nibble and strap match
  function automatic logic addr_match(input logic [DW-1:0] b,
                                      input logic [2:0]    sel);
    addr_match = (b[7:nvram_pkg::TYPE_LSB] == nvram_pkg::DEV_TYPE) &&
                 (b[3:nvram_pkg::SEL_LSB] == sel);
  endfunction

  function automatic logic is_hs_code(input logic [DW-1:0] b);
    is_hs_code = (b[7:nvram_pkg::HS_LSB] == nvram_pkg::HS_CODE);
  endfunction

  // ==========================================================
  // Protocol state
  // ==========================================================
  nvram_pkg::state_t state_q, state_d;   // Protocol phase
  logic [3:0]    bit_q, bit_d;           // Bit in byte, 8 = ack
  logic [DW-1:0] shift_q, shift_d;       // Shift register
  logic [AW-1:0] loc_q, loc_d;           // Location counter
  logic [6:0]    loc_hi_q, loc_hi_d;     // Held high byte
  logic          ack_q, ack_d;           // Drive ack in ninth clock
  logic          drv_q, drv_d;           // Drive low request
  logic          hs_q, hs_d;             // High speed flag
  logic          busy_q, busy_d;         // Registered busy flag
  logic          oe_n_q, oe_n_d;         // Registered SDA enable
  logic          wr_en;                  // Array write strobe
  logic [AW-1:0] mem_addr;               // Array address
  logic [DW-1:0] rd_data;                // Array read byte

  // full byte present when the eighth bit is sampled
  wire logic [DW-1:0] byte_in = {shift_q[6:0], sda_s};

  // Next state of the protocol engine
  always_comb begin
    state_d  = state_q;
    bit_d    = bit_q;
    shift_d  = shift_q;
    loc_d    = loc_q;
    loc_hi_d = loc_hi_q;
    ack_d    = ack_q;
    drv_d    = drv_q;
    hs_d     = hs_q;
    wr_en    = 1'b0;
    mem_addr = loc_q;
    if (stop_ev) begin
      // STOP aborts and leaves high speed
      state_d = nvram_pkg::ST_IDLE;
      drv_d   = 1'b0;
      ack_d   = 1'b0;
      hs_d    = 1'b0;
    end else if (start_ev) begin
      // next byte is a slave address
      state_d = nvram_pkg::ST_SLAVE;
      // First SCL fall after START is not a data bit
      bit_d   = 4'hf;
      drv_d   = 1'b0;
      ack_d   = 1'b0;
    end else if (state_q != nvram_pkg::ST_IDLE &&
                 state_q != nvram_pkg::ST_HSWT) begin
      if (scl_rise) begin
        if (bit_q == 4'h8) begin
          if (state_q == nvram_pkg::ST_RDATA && sda_s) begin
            state_d = nvram_pkg::ST_IDLE;
          end
        end else begin
          shift_d = byte_in;
          if (bit_q == 4'h7) begin
            case (state_q)
              nvram_pkg::ST_SLAVE: begin
                if (is_hs_code(byte_in)) begin
                  hs_d    = 1'b1;
                  state_d = nvram_pkg::ST_HSWT;
                end else if (addr_match(byte_in, sel_s)) begin
                  ack_d = 1'b1;
                  state_d = byte_in[nvram_pkg::DIR_BIT] ?
                            nvram_pkg::ST_RDATA : nvram_pkg::ST_ADRH;
                end else begin
                  state_d = nvram_pkg::ST_IDLE;
                end
              end
              nvram_pkg::ST_ADRH: begin
                loc_hi_d = byte_in[6:0];
                ack_d    = 1'b1;
                state_d  = nvram_pkg::ST_ADRL;
              end
              nvram_pkg::ST_ADRL: begin
                loc_d   = {loc_hi_q, byte_in};
                ack_d   = 1'b1;
                state_d = nvram_pkg::ST_WDATA;
              end
              nvram_pkg::ST_WDATA: begin
                if (!wp_s) begin
                  wr_en = 1'b1;
                  loc_d = loc_q + 1'b1;
                  ack_d = 1'b1;
                end else begin
                  ack_d = 1'b0;
                end
              end
              nvram_pkg::ST_RDATA: begin
                loc_d = loc_q + 1'b1;
                ack_d = 1'b0;
              end
              default: begin
                state_d = nvram_pkg::ST_IDLE;
              end
            endcase
          end
        end
      end else if (scl_fall) begin
        if (bit_q == 4'h7) begin
          bit_d = 4'h8;
          drv_d = ack_q;
          if (state_q == nvram_pkg::ST_IDLE ||
              state_q == nvram_pkg::ST_HSWT) begin
            drv_d = 1'b0;
          end
          // no ack on a write byte ends it
          if (state_q == nvram_pkg::ST_WDATA && !ack_q) begin
            state_d = nvram_pkg::ST_IDLE;
          end
        end else if (bit_q == 4'h8) begin
          bit_d = 4'h0;
          ack_d = 1'b0;
          // first bit of the next read byte
          drv_d = (state_q == nvram_pkg::ST_RDATA) ?
                  ~rd_data[7] : 1'b0;
          shift_d = rd_data;
        end else begin
          // Wraps f to 0 on the fall that follows START
          bit_d = bit_q + 4'h1;
          // Rise shifted left, so bit 7 is the next to send
          drv_d = (state_q == nvram_pkg::ST_RDATA) ?
                  ~shift_q[7] : 1'b0;
        end
      end
    end else if (state_q == nvram_pkg::ST_IDLE) begin
      drv_d = 1'b0;
    end
    // Outputs registered from their next values
    busy_d = (state_d != nvram_pkg::ST_IDLE);
    oe_n_d = ~drv_d;
  end

  // Register protocol state
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q  <= nvram_pkg::ST_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= nvram_pkg::BYTE_RESET;
      loc_q    <= nvram_pkg::LOC_RESET;
      loc_hi_q <= 7'h00;
      ack_q    <= 1'b0;
      drv_q    <= 1'b0;
      hs_q     <= 1'b0;
      busy_q   <= 1'b0;
      oe_n_q   <= 1'b1;
    end else if (clk_en) begin
      state_q  <= state_d;
      bit_q    <= bit_d;
      shift_q  <= shift_d;
      loc_q    <= loc_d;
      loc_hi_q <= loc_hi_d;
      ack_q    <= ack_d;
      drv_q    <= drv_d;
      hs_q     <= hs_d;
      busy_q   <= busy_d;
      oe_n_q   <= oe_n_d;
    end
  end

  // ==========================================================
  // Storage array
  // ==========================================================
  nvram_array #(
    .AW (AW),
    .DW (DW)
  ) u_array (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .wr_en   (wr_en),
    .addr    (mem_addr),
    .wr_data (byte_in),
    .rd_data (rd_data)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  // data out is always low, enable low pulls the line
  assign sda_o    = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign hs_mode  = hs_q;
  assign busy     = busy_q;

endmodule // nvram_i2c_slave

// ===== test/nvram_slave_chk.sv
// Purpose: protocol checks on the memory slave pins
// Assumes: master moves SDA only while SCL is low
// Notes:   address capture mirrors the slave at pin level
module nvram_slave_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n,
  input wire logic [2:0] chip_select_straps,
  input wire logic       write_protect,
  input wire logic       hs_mode,
  input wire logic       busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       scl_q;     // Previous SCL
  logic       sda_q;     // Previous SDA
  logic [3:0] cnt_q;     // Rises since START
  logic [3:0] cnt_d;
  logic [7:0] sh_q;      // First byte after START
  logic [7:0] sh_d;
  logic       start_ev;  // START seen on pins
  logic       sel_ok;    // First byte selects us

  default clocking cb @(posedge ref_clk); endclocking
  // A frozen block answers nothing, so checks pause with it
  default disable iff (!rst_n || !clk_en);

  // ==========================================================
  // Address capture
  // ==========================================================
  // Count rises, keep first eight bits
  always_comb begin
    start_ev = scl_i && scl_q && sda_q && !sda_i;
    sel_ok   = sh_q[7:4] == nvram_pkg::DEV_TYPE &&
               sh_q[3:1] == chip_select_straps;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    if (start_ev) begin
      cnt_d = 4'h0;
    end else if (scl_i && !scl_q && cnt_q < 4'h9) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q < 4'h8) begin
        sh_d = {sh_q[6:0], sda_i};
      end
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h9;
      sh_q  <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
    end
  end

  // ==========================================================
  // Properties
  // ==========================================================
  sequence start_s;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence stop_s;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  sequence ack_fall_s;
    cnt_q == 4'h8 && sel_ok && $fell(scl_i);
  endsequence

  chk_od_low:
  assert property (sda_o == 1'b0) else $error("sda_o not low");
  chk_hold_high:
  assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n))
    else $error("SDA drive moved while SCL high");
  chk_idle_free:
  assert property (!busy && !$past(busy) |-> sda_oe_n)
    else $error("SDA pulled while idle");
  chk_start_busy:
  assert property (start_s |-> ##[1:6] busy)
    else $error("START not taken");
  chk_stop_idle:
  assert property (stop_s |-> ##[1:6] (!busy && sda_oe_n))
    else $error("STOP did not idle");
  chk_hs_leave:
  assert property (stop_s |-> ##[1:6] !hs_mode)
    else $error("STOP kept high speed");
  chk_sel_ack:
  assert property (ack_fall_s |-> ##[2:6] !sda_oe_n [*4])
    else $error("Address not acknowledged");
  chk_no_select:
  assert property (cnt_q >= 4'h8 && !sel_ok |-> sda_oe_n)
    else $error("Drive after foreign address");
  chk_hs_enter:
  assert property (cnt_q == 4'h8 && $past(cnt_q) == 4'h7 &&
    sh_q[7:3] == nvram_pkg::HS_CODE |-> ##[1:6] hs_mode)
    else $error("Master code ignored");
endmodule // nvram_slave_chk

bind nvram_i2c_slave nvram_slave_chk nvram_slave_chk_i (
  .ref_clk, .rst_n, .clk_en, .scl_i, .sda_i, .sda_o, .sda_oe_n,
  .chip_select_straps, .write_protect, .hs_mode, .busy
);

// ===== test/nvram_master.sv
// Purpose: two-wire bus master model, 64 ns SCL
// Assumes: pull-ups on both lines, wired-AND SDA
// Notes:   SCL stands high between frames
module nvram_master (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  // data moves only while SCL low
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #16 scl = 1'b1;
    #16 r = sda_line;
    #16 scl = 1'b0;
    #16;
  endtask

  task automatic start_c;
    sda_rel = 1'b1;
    #16 scl = 1'b1;
    #16 sda_rel = 1'b0;
    #16 scl = 1'b0;
    #16;
  endtask

  // STOP only while master owns SDA
  task automatic stop_c;
    sda_rel = 1'b0;
    #16 scl = 1'b1;
    #16 sda_rel = 1'b1;
    #32;
  endtask

  // Leading bits of a byte, MSB first
  task automatic send_bits(input logic [7:0] b, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(b[i], r);
    end
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    send_bits(b, 8);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule // nvram_master

// ===== test/i2c_nvram_slave_interface_bench.sv
// Purpose: self-checking bench of the memory slave
// Assumes: master model on the far side of the pins
// Notes:   every scenario is a task that judges itself
module i2c_nvram_slave_interface_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk;
  logic       rst_n;
  logic       sda_o;
  logic       sda_oe_n;
  logic       hs_mode;
  logic       busy;
  logic       wp;
  logic       en;
  logic       ack;
  logic [7:0] rd;
  logic [2:0] straps;
  wire logic  scl;
  wire logic  sda_rel;
  wire logic  sda_line;
  int         fails;
  int         checks_done;

  // Wired-AND SDA with pull-up
  assign sda_line = sda_rel & (sda_oe_n | sda_o);

  nvram_i2c_slave nvram_i2c_slave_i (
    .ref_clk, .rst_n, .clk_en(en), .scl_i(scl), .sda_i(sda_line),
    .sda_o, .sda_oe_n, .chip_select_straps(straps),
    .write_protect(wp), .hs_mode, .busy
  );
  nvram_master nvram_master_i (.scl, .sda_rel, .sda_line);

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Write header setting the location
  task automatic head(input logic [15:0] loc);
    nvram_master_i.start_c();
    nvram_master_i.send_byte({4'ha, straps, 1'b0}, ack);
    check(ack, 1'b1);
    nvram_master_i.send_byte(loc[15:8], ack);
    check(ack, 1'b1);
    nvram_master_i.send_byte(loc[7:0], ack);
    check(ack, 1'b1);
  endtask

  // Current location read, last byte unacknowledged
  task automatic rd_cur(input logic [7:0] exp [$]);
    nvram_master_i.start_c();
    nvram_master_i.send_byte({4'ha, straps, 1'b1}, ack);
    check(ack, 1'b1);
    foreach (exp[i]) begin
      nvram_master_i.recv_byte(i < exp.size() - 1, rd);
      check(rd, exp[i]);
    end
    check(busy, 1'b0);
    nvram_master_i.stop_c();
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Burst across the top location, top bit ignored
  task automatic s_wrap;
    head(16'hfffe);
    for (int i = 0; i < 3; i++) begin
      nvram_master_i.send_byte(8'h5a + 8'(i * 37), ack);
      check(ack, 1'b1);
    end
    head(16'h7ffe);
    rd_cur('{8'h5a, 8'h7f, 8'ha4});
  endtask

  // Protected write refused, counter held
  task automatic s_protect;
    head(16'h0010);
    nvram_master_i.send_byte(8'h3c, ack);
    check(ack, 1'b1);
    nvram_master_i.stop_c();
    @(posedge ref_clk);
    #1.2 wp = 1'b1;
    head(16'h0010);
    nvram_master_i.send_byte(8'hc3, ack);
    check(ack, 1'b0);
    nvram_master_i.stop_c();
    @(posedge ref_clk);
    #1.2 wp = 1'b0;
    rd_cur('{8'h3c});
  endtask

  // START before eighth bit leaves memory alone
  // The START itself raises SCL once, so only six bits go first
  task automatic s_abort;
    head(16'h0010);
    nvram_master_i.send_bits(8'hff, 6);
    rd_cur('{8'h3c});
  endtask

  // Every strap value, wrong strap and wrong type
  task automatic s_select;
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      #1.2 straps = 3'(s);
      nvram_master_i.start_c();
      nvram_master_i.send_byte({4'ha, 3'(s) ^ 3'h5, 1'b0}, ack);
      check(ack, 1'b0);
      nvram_master_i.start_c();
      nvram_master_i.send_byte({4'hb, 3'(s), 1'b0}, ack);
      check(ack, 1'b0);
      nvram_master_i.start_c();
      // Write direction: no read of unwritten cells
      nvram_master_i.send_byte({4'ha, 3'(s), 1'b0}, ack);
      check(ack, 1'b1);
      nvram_master_i.stop_c();
    end
  endtask

  // Frozen block ignores a whole write frame
  task automatic s_freeze;
    @(posedge ref_clk);
    #1.2 en = 1'b0;
    nvram_master_i.start_c();
    nvram_master_i.send_byte({4'ha, straps, 1'b0}, ack);
    check(ack, 1'b0);
    nvram_master_i.send_byte(8'h00, ack);
    nvram_master_i.send_byte(8'h10, ack);
    nvram_master_i.send_byte(8'hee, ack);
    nvram_master_i.stop_c();
    @(posedge ref_clk);
    #1.2 en = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1.2;
    check(busy, 1'b0);
    head(16'h0010);
    rd_cur('{8'h3c});
  endtask

  // Master code, addressed transfer, STOP leaves
  task automatic s_hs;
    nvram_master_i.start_c();
    nvram_master_i.send_byte(8'h0b, ack);
    check(ack, 1'b0);
    check(hs_mode, 1'b1);
    head(16'h0010);
    nvram_master_i.stop_c();
    check(hs_mode, 1'b0);
    check(busy, 1'b0);
  endtask

  // Free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Main sequence
  initial begin
    rst_n       = 1'b0;
    wp          = 1'b0;
    en          = 1'b1;
    straps      = 3'h2;
    fails       = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    #1.2 rst_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1.2;
    check(sda_oe_n, 1'b1);
    s_wrap();
    s_protect();
    s_abort();
    s_select();
    s_hs();
    s_freeze();
    conclude();
  end
endmodule // i2c_nvram_slave_interface_bench
